// ### src/csi_pkg.sv
// constants and types shared by the status indicator logic
// ****************************************************************
// Summary of operation
// RQ1: stop state: run lamp 2 s on/off
// RQ2: run state: run lamp 0.25 s on/off
// RQ3: run/stop only by programmer, kept non-volatile
// RQ4: fitted module: run at power-up after syntax ok
// RQ5: error forces stop and lights fault lamp (an error during ST_BOOT only holds ST_BOOT; the unit may then still run)
// RQ6: minor: power cycle resumes; serious: refuse until cleared
// RQ7: fault lamp off when healthy, steady on system error
// RQ8: anomaly: fault lamp flashes 0.5 s, code lamps
// RQ9: binary code, bit 3 msb, 11-15 reserved
// RQ10: codes 1 to 5 meanings
// RQ11: codes 6 to 10 meanings
// RQ12: serial port slave only, reply after request
// RQ13: rx/tx lamps lit exactly during transfer
// RQ14: input lamp follows its input
// RQ15: output lamp follows driven output
// RQ16: one free-running timebase, phases restart on change
// RQ17: code overrides output lamps until anomaly clears
// ****************************************************************
package csi_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ          = 20_000_000;
    localparam int TICK_MS         = 1;
    localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int STOP_PHASE_MS   = 2000;
    localparam int RUN_PHASE_MS    = 250;
    localparam int FLASH_PHASE_MS  = 500;
    localparam int PHASE_W         = 16;
    localparam logic [PHASE_W-1:0] STOP_PHASE_TICKS  = PHASE_W'(STOP_PHASE_MS / TICK_MS);
    localparam logic [PHASE_W-1:0] RUN_PHASE_TICKS   = PHASE_W'(RUN_PHASE_MS / TICK_MS);
    localparam logic [PHASE_W-1:0] FLASH_PHASE_TICKS = PHASE_W'(FLASH_PHASE_MS / TICK_MS);

    // ************************************************************
    // error codes
    // ************************************************************
    localparam int CODE_W = 4;
    localparam int CODE_LAMPS = 4;
    localparam logic [3:0] ERR_NONE          = 4'h0;
    localparam logic [3:0] ERR_UNSUPPORTED   = 4'h1; // RQ10
    localparam logic [3:0] ERR_ID_MISMATCH   = 4'h2; // RQ10
    localparam logic [3:0] ERR_CHECKSUM      = 4'h3; // RQ10
    localparam logic [3:0] ERR_STACK         = 4'h4; // RQ10
    localparam logic [3:0] ERR_WATCHDOG      = 4'h5; // RQ10
    localparam logic [3:0] ERR_IO_EXCEEDED   = 4'h6; // RQ11
    localparam logic [3:0] ERR_SYNTAX        = 4'h7; // RQ11
    localparam logic [3:0] ERR_EXP_MODULES   = 4'h8; // RQ11
    localparam logic [3:0] ERR_EXP_POINTS    = 4'h9; // RQ11
    localparam logic [3:0] ERR_FLASH_CRC     = 4'hA; // RQ11
    localparam logic [3:0] ERR_RESERVED_LO   = 4'hB; // RQ9

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [3:0] {
        ST_BOOT  = 4'b0001,
        ST_CHECK = 4'b0010,
        ST_STOP  = 4'b0100,
        ST_RUN   = 4'b1000
    } csi_state_type;

    typedef struct packed {
        logic             event_valid;
        logic             serious;
        logic [CODE_W-1:0] code;
    } csi_fault_type;

    typedef struct packed {
        logic rx_active;
        logic tx_active;
    } csi_serial_type;
endpackage

// ### src/csi_blink.sv
// lamp phase generator driven by the shared millisecond tick
`timescale 1ns/1ps
`default_nettype none
module csi_blink
    import csi_pkg::*;
(
    // clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               resetn_i,
    // control
    input  wire logic               tick_i,
    input  wire logic               restart_i,
    input  wire logic [PHASE_W-1:0] phase_ticks_i,
    // lamp
    output logic                    lamp_o
);
    logic [PHASE_W-1:0] cnt_reg;
    logic [PHASE_W-1:0] cnt_next;
    logic               lamp_reg;
    logic               lamp_next;

    // ************************************************************
    // phase counting
    // ************************************************************
    always_comb begin
        cnt_next  = cnt_reg;
        lamp_next = lamp_reg;
        if (restart_i) begin
            cnt_next  = '0; // RQ16
            lamp_next = 1'b1;
        end else if (tick_i) begin
            if (cnt_reg + PHASE_W'(1) >= phase_ticks_i) begin
                cnt_next  = '0;
                lamp_next = ~lamp_reg;
            end else begin
                cnt_next = cnt_reg + PHASE_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg  <= '0;
            lamp_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            lamp_reg <= lamp_next;
        end
    end

    assign lamp_o = lamp_reg;
endmodule
`default_nettype wire

// ### src/csi_status_lamps.sv
// run/fault/serial/io status lamp controller
`timescale 1ns/1ps
`default_nettype none
module csi_status_lamps
    import csi_pkg::*;
#(
    parameter int NUM_IN      = 8,
    parameter int NUM_OUT     = 8,
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    // clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               resetn_i,
    // programmer command and non-volatile state
    input  wire logic               cmd_valid_i,
    input  wire logic               cmd_run_i,
    input  wire logic               nv_run_i,
    output logic                    nv_write_o,
    output logic                    nv_run_o,
    // plug-in program module
    input  wire logic               module_fitted_i,
    input  wire logic               module_check_done_i,
    input  wire logic               module_syntax_ok_i,
    // faults
    input  wire csi_fault_type      fault_i,
    input  wire logic               fault_clear_i,
    // builtin serial port
    input  wire csi_serial_type     serial_i,
    output logic                    tx_grant_o,
    // io points
    input  wire logic [NUM_IN-1:0]  input_state_i,
    input  wire logic [NUM_OUT-1:0] output_state_i,
    output logic [NUM_OUT-1:0]      output_drive_o,
    // lamps
    output logic                    run_lamp_o,
    output logic                    fault_lamp_o,
    output logic                    rx_lamp_o,
    output logic                    tx_lamp_o,
    output logic [NUM_IN-1:0]       input_lamp_o,
    output logic [NUM_OUT-1:0]      output_lamp_o,
    // state
    output logic                    running_o
);
    function automatic logic code_shown(input logic [CODE_W-1:0] c);
        code_shown = (c != ERR_NONE);
    endfunction

    // ************************************************************
    // free-running timebase
    // ************************************************************
    logic [31:0] tb_reg;
    logic [31:0] tb_next;
    logic        tick_reg;
    logic        tick_next;

    always_comb begin
        tick_next = (tb_reg == 32'(TICK_CYCLES_P - 1)); // RQ16
        tb_next   = tick_next ? 32'h0000_0000 : tb_reg + 32'h0000_0001;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tb_reg   <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else begin
            tb_reg   <= tb_next;
            tick_reg <= tick_next;
        end
    end

    // ************************************************************
    // run/stop and fault state
    // ************************************************************
    csi_state_type      state_reg;
    csi_state_type      state_next;
    logic               fault_reg;
    logic               fault_next;
    logic               serious_reg;
    logic               serious_next;
    logic [CODE_W-1:0]  code_reg;
    logic [CODE_W-1:0]  code_next;
    logic               nv_write_reg;
    logic               nv_write_next;
    logic               nv_run_reg;
    logic               nv_run_next;

    always_comb begin
        state_next    = state_reg;
        fault_next    = fault_reg;
        serious_next  = serious_reg;
        code_next     = code_reg;
        nv_write_next = 1'b0;
        nv_run_next   = nv_run_reg;
        // serious faults clear on request or at power-up; minor ones only at power-up
        if (fault_clear_i && serious_reg) begin
            fault_next   = 1'b0; // RQ6
            serious_next = 1'b0;
            code_next    = ERR_NONE; // RQ17
        end
        case (state_reg)
            ST_BOOT: begin
                nv_run_next = nv_run_i; // RQ3
                if (module_fitted_i)
                    state_next = ST_CHECK;
                else
                    state_next = nv_run_i ? ST_RUN : ST_STOP; // RQ3
            end
            ST_CHECK: begin
                if (module_check_done_i) begin
                    if (module_syntax_ok_i) begin
                        state_next = ST_RUN; // RQ4
                    end else begin
                        state_next = ST_STOP;
                        fault_next = 1'b1;
                        code_next  = ERR_SYNTAX;
                    end
                end
            end
            ST_STOP, ST_RUN: begin
                // faulted unit refuses programmer run/stop
                if (cmd_valid_i && !fault_reg) begin
                    state_next    = cmd_run_i ? ST_RUN : ST_STOP; // RQ3
                    nv_write_next = 1'b1;
                    nv_run_next   = cmd_run_i;
                end
            end
            default: state_next = ST_BOOT;
        endcase
        // an error arriving with a clear wins; stop is not saved so power cycle resumes
        if (fault_i.event_valid) begin
            state_next    = (state_reg == ST_BOOT) ? ST_BOOT : ST_STOP; // RQ5
            fault_next    = 1'b1; // RQ5
            serious_next  = serious_reg | fault_i.serious; // RQ6
            code_next     = fault_i.code; // RQ9
            nv_write_next = 1'b0;
            nv_run_next   = nv_run_reg;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg    <= ST_BOOT;
            fault_reg    <= 1'b0;
            serious_reg  <= 1'b0;
            code_reg     <= ERR_NONE;
            nv_write_reg <= 1'b0;
            nv_run_reg   <= 1'b0;
        end else begin
            state_reg    <= state_next;
            fault_reg    <= fault_next;
            serious_reg  <= serious_next;
            code_reg     <= code_next;
            nv_write_reg <= nv_write_next;
            nv_run_reg   <= nv_run_next;
        end
    end

    // ************************************************************
    // blink generators
    // ************************************************************
    logic               run_phase_restart;
    logic               flash_restart;
    logic [PHASE_W-1:0] run_phase_ticks;
    logic               run_blink;
    logic               flash_blink;

    assign run_phase_restart = (state_next != state_reg) || (fault_next != fault_reg); // RQ16
    assign flash_restart     = (code_next != code_reg); // RQ16
    assign run_phase_ticks   = (state_reg == ST_RUN) ? RUN_PHASE_TICKS : STOP_PHASE_TICKS; // RQ1 RQ2

    csi_blink u_run_blink (
        .ref_clk_i     (ref_clk_i),
        .resetn_i      (resetn_i),
        .tick_i        (tick_reg),
        .restart_i     (run_phase_restart),
        .phase_ticks_i (run_phase_ticks),
        .lamp_o        (run_blink)
    );

    csi_blink u_flash_blink (
        .ref_clk_i     (ref_clk_i),
        .resetn_i      (resetn_i),
        .tick_i        (tick_reg),
        .restart_i     (flash_restart),
        .phase_ticks_i (FLASH_PHASE_TICKS),
        .lamp_o        (flash_blink)
    );

    // ************************************************************
    // serial slave gating
    // ************************************************************
    logic rx_prev_reg;
    logic rx_prev_next;
    logic grant_reg;
    logic grant_next;
    logic tx_prev_reg;
    logic tx_prev_next;

    always_comb begin
        rx_prev_next = serial_i.rx_active;
        tx_prev_next = serial_i.tx_active & grant_reg;
        grant_next   = grant_reg;
        // end of a reply closes the grant; the end of a new request reopens it
        if (tx_prev_reg && !serial_i.tx_active)
            grant_next = 1'b0; // RQ12
        if (rx_prev_reg && !serial_i.rx_active)
            grant_next = 1'b1; // RQ12
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_prev_reg <= 1'b0;
            tx_prev_reg <= 1'b0;
            grant_reg   <= 1'b0;
        end else begin
            rx_prev_reg <= rx_prev_next;
            tx_prev_reg <= tx_prev_next;
            grant_reg   <= grant_next;
        end
    end

    // ************************************************************
    // lamp and output registers
    // ************************************************************
    logic                run_lamp_reg;
    logic                fault_lamp_reg;
    logic                rx_lamp_reg;
    logic                tx_lamp_reg;
    logic [NUM_IN-1:0]   in_lamp_reg;
    logic [NUM_OUT-1:0]  out_lamp_reg;
    logic [NUM_OUT-1:0]  out_lamp_next;
    logic [NUM_OUT-1:0]  drive_reg;
    logic [NUM_OUT-1:0]  drive_next;
    logic                fault_lamp_next;

    always_comb begin
        if (code_shown(code_reg))
            fault_lamp_next = flash_blink; // RQ8
        else
            fault_lamp_next = fault_reg; // RQ7
    end

    for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
        if (i < CODE_LAMPS) begin : g_code
            // code lamps: code wins and the load is held off meanwhile
            assign out_lamp_next[i] = code_shown(code_reg) ? code_reg[i] : output_state_i[i]; // RQ8 RQ9 RQ17
            assign drive_next[i]    = code_shown(code_reg) ? 1'b0 : output_state_i[i]; // RQ8
        end else begin : g_plain
            assign out_lamp_next[i] = output_state_i[i]; // RQ15
            assign drive_next[i]    = output_state_i[i];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_lamp_reg   <= 1'b0;
            fault_lamp_reg <= 1'b0;
            rx_lamp_reg    <= 1'b0;
            tx_lamp_reg    <= 1'b0;
            in_lamp_reg    <= '0;
            out_lamp_reg   <= '0;
            drive_reg      <= '0;
        end else begin
            run_lamp_reg   <= (state_reg == ST_BOOT || state_reg == ST_CHECK) ? 1'b0 : run_blink; // RQ1 RQ2
            fault_lamp_reg <= fault_lamp_next;
            rx_lamp_reg    <= serial_i.rx_active; // RQ13
            tx_lamp_reg    <= serial_i.tx_active & grant_reg; // RQ13
            in_lamp_reg    <= input_state_i; // RQ14
            out_lamp_reg   <= out_lamp_next;
            drive_reg      <= drive_next; // RQ15
        end
    end

    assign run_lamp_o     = run_lamp_reg;
    assign fault_lamp_o   = fault_lamp_reg;
    assign rx_lamp_o      = rx_lamp_reg;
    assign tx_lamp_o      = tx_lamp_reg;
    assign tx_grant_o     = grant_reg;
    assign input_lamp_o   = in_lamp_reg;
    assign output_lamp_o  = out_lamp_reg;
    assign output_drive_o = drive_reg;
    assign nv_write_o     = nv_write_reg;
    assign nv_run_o       = nv_run_reg;
    assign running_o      = state_reg[3]; // one-hot run bit keeps the port a plain flop
endmodule
`default_nettype wire

// ### bench/csi_status_lamps_monitor.sv
// concurrent checks on the status lamp controller ports
`timescale 1ns/1ps
`default_nettype none
module csi_status_lamps_monitor
    import csi_pkg::*;
#(
    parameter int NUM_IN  = 8,
    parameter int NUM_OUT = 8
) (
    // clock, reset, inputs
    input wire logic               ref_clk_i,
    input wire logic               resetn_i,
    input wire logic               cmd_valid_i,
    input wire logic               cmd_run_i,
    input wire csi_fault_type      fault_i,
    input wire logic               fault_clear_i,
    input wire csi_serial_type     serial_i,
    input wire logic [NUM_IN-1:0]  input_state_i,
    input wire logic [NUM_OUT-1:0] output_state_i,
    // outputs
    input wire logic               nv_write_o,
    input wire logic               nv_run_o,
    input wire logic               tx_grant_o,
    input wire logic               run_lamp_o,
    input wire logic               fault_lamp_o,
    input wire logic               rx_lamp_o,
    input wire logic               tx_lamp_o,
    input wire logic [NUM_IN-1:0]  input_lamp_o,
    input wire logic [NUM_OUT-1:0] output_lamp_o,
    input wire logic [NUM_OUT-1:0] output_drive_o,
    input wire logic               running_o
);
    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    in_lamp_follow_a: assert property ($past(resetn_i) |-> input_lamp_o == $past(input_state_i))
        else $error("input lamps do not follow inputs");
    rx_lamp_track_a: assert property ($past(resetn_i) |-> rx_lamp_o == $past(serial_i.rx_active))
        else $error("rx lamp does not track reception");
    tx_lamp_track_a: assert property ($past(resetn_i) |->
            tx_lamp_o == $past(serial_i.tx_active && tx_grant_o))
        else $error("tx lamp does not track reply");
    tx_no_request_a: assert property (!serial_i.rx_active [*4] ##0 !tx_grant_o |=> !tx_grant_o)
        else $error("reply granted without request");
    fault_forces_stop_a: assert property (fault_i.event_valid |=> !running_o)
        else $error("fault did not force stop");
    code_on_lamps_a: assert property (fault_i.event_valid && fault_i.code != 4'h0 ##1 !fault_i.event_valid
            |=> output_lamp_o[3:0] == $past(fault_i.code, 2) && output_drive_o[3:0] == 4'h0)
        else $error("error code not shown");
    steady_fault_a: assert property (fault_i.event_valid && fault_i.code == 4'h0
            ##1 (!fault_clear_i && !fault_i.event_valid) [*3] |-> fault_lamp_o [*3])
        else $error("system error lamp not steady");
    nv_write_val_a: assert property (nv_write_o |-> $past(cmd_valid_i) && nv_run_o == $past(cmd_run_i)
            && running_o == nv_run_o)
        else $error("stored state wrong");
    run_restart_a: assert property (nv_write_o && running_o != $past(running_o) |=> run_lamp_o)
        else $error("run lamp phase not restarted");
    drive_upper_a: assert property ($past(resetn_i) |->
            output_drive_o[NUM_OUT-1:4] == $past(output_state_i[NUM_OUT-1:4]))
        else $error("output drive does not follow");

    cmd_run_c: cover property (nv_write_o && nv_run_o);
    code_shown_c: cover property (fault_i.event_valid && fault_i.code != 4'h0);
    tx_lit_c: cover property (tx_lamp_o);
endmodule
bind csi_status_lamps csi_status_lamps_monitor #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) u_mon (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i), .cmd_run_i(cmd_run_i),
    .fault_i(fault_i), .fault_clear_i(fault_clear_i), .serial_i(serial_i), .input_state_i(input_state_i),
    .output_state_i(output_state_i), .nv_write_o(nv_write_o), .nv_run_o(nv_run_o), .tx_grant_o(tx_grant_o),
    .run_lamp_o(run_lamp_o), .fault_lamp_o(fault_lamp_o), .rx_lamp_o(rx_lamp_o), .tx_lamp_o(tx_lamp_o),
    .input_lamp_o(input_lamp_o), .output_lamp_o(output_lamp_o), .output_drive_o(output_drive_o),
    .running_o(running_o));
`default_nettype wire

// ### bench/csi_host_model.sv
// host on the builtin serial port: request, then reply window
`timescale 1ns/1ps
`default_nettype none
module csi_host_model
    import csi_pkg::*;
#(
    parameter int LEN = 8
) (
    input  wire logic       ref_clk_i,
    input  wire logic       req_i,
    input  wire logic       rude_i,
    input  wire logic       grant_i,
    input  wire logic [3:0] gap_i,
    output csi_serial_type  serial_o
);
    int n;
    initial serial_o = '0;
    always @(posedge ref_clk_i) begin
        if (rude_i) begin
            // reply with no request, only when the bench asks
            serial_o.tx_active <= 1'b1;
            repeat (LEN) @(posedge ref_clk_i);
            serial_o.tx_active <= 1'b0;
        end else if (req_i) begin
            serial_o.rx_active <= 1'b1;
            repeat (LEN) @(posedge ref_clk_i);
            serial_o.rx_active <= 1'b0;
            n = 0;
            while (!grant_i && n < 50) begin
                @(posedge ref_clk_i);
                n++;
            end
            // slow answers: gap before the reply
            repeat (gap_i) @(posedge ref_clk_i);
            serial_o.tx_active <= 1'b1;
            repeat (LEN) @(posedge ref_clk_i);
            serial_o.tx_active <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### bench/csi_status_lamps_tb.sv
// self-checking bench for the status lamp controller
`timescale 1ns/1ps
`default_nettype none
module csi_status_lamps_tb;
    import csi_pkg::*;
    localparam int TK = 4;
    logic           ref_clk_i = 0, resetn_i = 0, cmd_valid_i = 0, cmd_run_i = 0, nv_run_i = 0;
    logic           module_fitted_i = 0, module_check_done_i = 0, module_syntax_ok_i = 0;
    logic           fault_clear_i = 0, req = 0, rude = 0;
    logic [3:0]     gap = 0;
    csi_fault_type  fault_i = '0;
    csi_serial_type serial_i;
    logic [7:0]     input_state_i = '0, output_state_i = '0, output_drive_o, input_lamp_o, output_lamp_o;
    logic           nv_write_o, nv_run_o, tx_grant_o, run_lamp_o, fault_lamp_o, rx_lamp_o, tx_lamp_o, running_o;
    int             errors = 0, n_tests = 0, seed = 32'hd54f, k;

    always #25 ref_clk_i = ~ref_clk_i;
    // non-volatile store stand-in
    always @(posedge ref_clk_i) if (nv_write_o) nv_run_i <= nv_run_o;

    csi_status_lamps #(.NUM_IN(8), .NUM_OUT(8), .TICK_CYCLES_P(TK)) u_csi_status_lamps (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i), .cmd_run_i(cmd_run_i),
        .nv_run_i(nv_run_i), .nv_write_o(nv_write_o), .nv_run_o(nv_run_o), .module_fitted_i(module_fitted_i),
        .module_check_done_i(module_check_done_i), .module_syntax_ok_i(module_syntax_ok_i), .fault_i(fault_i),
        .fault_clear_i(fault_clear_i), .serial_i(serial_i), .tx_grant_o(tx_grant_o),
        .input_state_i(input_state_i), .output_state_i(output_state_i), .output_drive_o(output_drive_o),
        .run_lamp_o(run_lamp_o), .fault_lamp_o(fault_lamp_o), .rx_lamp_o(rx_lamp_o), .tx_lamp_o(tx_lamp_o),
        .input_lamp_o(input_lamp_o), .output_lamp_o(output_lamp_o), .running_o(running_o));
    csi_host_model #(.LEN(8)) u_csi_host_model (.ref_clk_i(ref_clk_i), .req_i(req), .rude_i(rude),
        .grant_i(tx_grant_o), .gap_i(gap), .serial_o(serial_i));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic results();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic do_reset();
        @(posedge ref_clk_i);
        resetn_i <= 1'b0;
        cyc(4);
        @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        cyc(3);
    endtask
    task automatic cmd(input logic r);
        @(posedge ref_clk_i);
        cmd_valid_i <= 1'b1;
        cmd_run_i <= r;
        @(posedge ref_clk_i);
        cmd_valid_i <= 1'b0;
        #1;
    endtask
    task automatic flt(input logic s, input logic [3:0] c);
        @(posedge ref_clk_i);
        fault_i <= {1'b1, s, c};
        @(posedge ref_clk_i);
        fault_i <= '0;
        cyc(1);
    endtask
    task automatic clr();
        @(posedge ref_clk_i);
        fault_clear_i <= 1'b1;
        @(posedge ref_clk_i);
        fault_clear_i <= 1'b0;
        cyc(3);
    endtask
    // wait for a lamp edge, bounded
    task automatic edge_wait(input logic f, output int n);
        logic v;
        v = f ? fault_lamp_o : run_lamp_o;
        n = 0;
        while ((f ? fault_lamp_o : run_lamp_o) === v) begin
            cyc(1);
            n++;
            if (n > 20000) begin
                errors++;
                results();
            end
        end
    endtask
    // expected cycles from the phase in ms and the tick length
    function automatic logic near(input int n, input int ms);
        return n >= ms * TK - TK && n <= ms * TK + TK;
    endfunction
    task automatic phase(input logic f, input int ms, input string m);
        int n;
        edge_wait(f, n);
        edge_wait(f, n);
        chk(8'(near(n, ms)), 8'h01, m);
    endtask

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        do_reset();
        chk({running_o, fault_lamp_o}, 8'h00, "boot stop");
        phase(1'b0, STOP_PHASE_MS, "stop blink");
        edge_wait(1'b0, k);
        cmd(1'b1);
        chk({nv_write_o, nv_run_o, running_o}, 8'h07, "run cmd");
        cyc(1);
        chk(run_lamp_o, 8'h01, "restart");
        phase(1'b0, RUN_PHASE_MS, "run blink");
        chk(fault_lamp_o, 8'h00, "healthy");
        for (k = 0; k < 16; k++) begin
            @(posedge ref_clk_i);
            input_state_i <= 8'($random(seed));
            output_state_i <= 8'($random(seed));
            cyc(3);
            chk(input_lamp_o, input_state_i, "in lamp");
            chk(output_lamp_o, output_state_i, "out lamp");
            chk(output_drive_o, output_state_i, "drive");
        end
        @(posedge ref_clk_i);
        rude <= 1'b1;
        @(posedge ref_clk_i);
        rude <= 1'b0;
        cyc(3);
        chk({tx_lamp_o, tx_grant_o}, 8'h00, "tx refused");
        for (k = 0; k < 3; k++) begin
            cyc(12);
            @(posedge ref_clk_i);
            gap <= 4'($random(seed));
            req <= 1'b1;
            @(posedge ref_clk_i);
            req <= 1'b0;
            cyc(3);
            chk({rx_lamp_o, tx_lamp_o}, 8'h02, "rx lit");
            for (int n = 0; n < 60 && tx_lamp_o !== 1'b1; n++) cyc(1);
            chk({rx_lamp_o, tx_lamp_o}, 8'h01, "tx lit");
            if (tx_lamp_o !== 1'b1) results();
            cyc(12);
            chk({rx_lamp_o, tx_lamp_o, tx_grant_o}, 8'h00, "idle");
        end
        for (k = 1; k < 16; k++) begin
            flt(1'b1, 4'(k));
            chk({running_o, fault_lamp_o, output_lamp_o[3:0]}, {2'b01, 4'(k)}, "code");
            chk(output_drive_o[3:0], 8'h00, "code drive");
            if (k == 5) phase(1'b1, FLASH_PHASE_MS, "flash");
            cmd(1'b1);
            chk(running_o, 8'h00, "refused");
            clr();
            chk(output_lamp_o[3:0], output_state_i[3:0], "lamps back");
            cmd(1'b1);
            chk(running_o, 8'h01, "cleared");
        end
        flt(1'b1, 4'h0);
        for (k = 0; k < 30; k++) begin
            cyc(100);
            chk({running_o, fault_lamp_o}, 8'h01, "steady");
        end
        clr();
        cmd(1'b1);
        flt(1'b0, 4'h5);
        clr();
        cmd(1'b1);
        chk(running_o, 8'h00, "minor held");
        do_reset();
        chk({running_o, fault_lamp_o}, 8'h02, "resume");
        cmd(1'b0);
        @(posedge ref_clk_i);
        module_fitted_i <= 1'b1;
        do_reset();
        chk(running_o, 8'h00, "checking");
        @(posedge ref_clk_i);
        module_check_done_i <= 1'b1;
        module_syntax_ok_i <= 1'b1;
        cyc(3);
        chk(running_o, 8'h01, "module run");
        @(posedge ref_clk_i);
        module_syntax_ok_i <= 1'b0;
        do_reset();
        chk({running_o, output_lamp_o[3:0]}, 8'h07, "syntax code");
        results();
    end
endmodule
`default_nettype wire
